// ### design/fwd_filter.v
// Purpose: analyzer forwarding filter for access control and aggregation
// Assumes: one frame descriptor per cycle, parsed flow fields supplied
// Notes:   masks and tables are plain ports or internal tables written
//          through a simple port; decision leaves through a skid buffer
`default_nettype none
`include "fwd_filter_defs.vh"

module fwd_filter (
  // clock and reset
  input  wire                      sys_clk,
  input  wire                      rst_n,
  // per-port and global learning, redirect and aggregation controls
  input  wire [`PORT_MSB:0]        reserved_addr_redirect_en,
  input  wire [`QUEUE_W-1:0]       reserved_addr_queue_sel,
  input  wire [`PORT_MSB:0]        learning_on,
  input  wire [`PORT_MSB:0]        learn_copy_to_cpu,
  input  wire [`PORT_MSB:0]        learn_frame_discard,
  input  wire [`PORT_MSB:0]        automatic_learning,
  input  wire                      skip_learn_on_vlan_filter,
  input  wire [`ACFG_W-1:0]        aggregation_code_cfg,
  // aggregation and source mask write port
  input  wire                      mask_wr,
  input  wire                      mask_is_src,
  input  wire [`PORT_W-1:0]        mask_idx,
  input  wire [`PORT_MSB:0]        mask_data,
  // vlan table command port
  input  wire [`VLAN_CMD_W-1:0]    vlan_table_op,
  input  wire [`VLAN_W-1:0]        vlan_table_index,
  input  wire                      vlan_ingress_filter_on,
  input  wire [`PORT_MSB:0]        vlan_member_ports,
  // frame descriptor in
  input  wire                      frm_valid,
  output wire                      frm_ready,
  input  wire [`PORT_W-1:0]        frm_src_port,
  input  wire [`VLAN_W-1:0]        frm_vid,
  input  wire [47:0]               frm_dmac,
  input  wire [47:0]               frm_smac,
  input  wire                      frm_smac_known,
  input  wire [`PORT_MSB:0]        frm_dest,
  input  wire                      frm_is_ip4,
  input  wire                      frm_is_ip6,
  input  wire [31:0]               frm_sip,
  input  wire [31:0]               frm_dip,
  input  wire [31:0]               frm_l4_ports,
  input  wire [19:0]               frm_flow_label,
  // decision out
  output wire                      dec_valid,
  input  wire                      dec_ready,
  output wire [`DEC_W-1:0]         dec_action,
  output wire [`QUEUE_W-1:0]       dec_queue,
  output wire [`PORT_MSB:0]        dec_ports,
  output wire [`AC_MSB:0]          dec_code,
  output wire                      dec_learn
);

  localparam DEC_BITS = `DEC_W + `QUEUE_W + `NUM_PORTS + `AC_W + 1;

  // -------------------------------------------------------------------------
  // mask and vlan storage
  // -------------------------------------------------------------------------
  reg [`PORT_MSB:0]      aggr_mask [0:`AGGR_MASKS-1];
  reg [`PORT_MSB:0]      src_mask  [0:`PORT_MSB];
  reg [`VLAN_ENTRY_W-1:0] vlan_tbl [0:`VLAN_DEPTH-1];
  reg [15:0]             lfsr;
  integer                i;

  // masks reset open so an unconfigured switch forwards
  // sixteen masks bound a group to sixteen members
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < `AGGR_MASKS; i = i + 1) begin
        aggr_mask[i] <= {`NUM_PORTS{1'b1}};
      end
      for (i = 0; i < `NUM_PORTS; i = i + 1) begin
        src_mask[i] <= {`NUM_PORTS{1'b1}};
      end
    end else if (mask_wr) begin
      if (!mask_is_src) begin
        aggr_mask[mask_idx[`AC_MSB:0]] <= mask_data;
      end else if (mask_idx <= `PORT_MSB) begin
        src_mask[mask_idx] <= mask_data;
      end
    end
  end

  // vlan table has no reset; software writes it before enabling traffic
  always @(posedge sys_clk) begin
    // write command stores filter flag and mask
    if (vlan_table_op == `VLAN_CMD_WRITE) begin
      vlan_tbl[vlan_table_index] <= {vlan_ingress_filter_on, vlan_member_ports};
    end
  end

  // free-running pseudo-random source for the random code option
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lfsr <= `LFSR_SEED;
    end else begin
      lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    end
  end

  // -------------------------------------------------------------------------
  // aggregation code
  // -------------------------------------------------------------------------
  function [`AC_MSB:0] fold48;
    input [47:0] v;
    integer k;
    begin
      fold48 = {`AC_W{1'b0}};
      for (k = 0; k < 48; k = k + `AC_W) begin
        fold48 = fold48 ^ v[k +: `AC_W];
      end
    end
  endfunction

  reg [`AC_MSB:0] code;

  // only flow fields feed the hash unless the random option is set, so a flow keeps its port
  // each contribution gated by its own enable
  always @* begin
    code = {`AC_W{1'b0}};
    if (aggregation_code_cfg[`ACFG_SMAC])
      code = code ^ fold48(frm_smac);
    if (aggregation_code_cfg[`ACFG_DMAC])
      code = code ^ fold48(frm_dmac);
    if (aggregation_code_cfg[`ACFG_SIPDIP] && frm_is_ip4)
      code = code ^ fold48({16'h0000, frm_sip ^ frm_dip});
    if (aggregation_code_cfg[`ACFG_IP4PORT] && frm_is_ip4)
      code = code ^ fold48({16'h0000, frm_l4_ports});
    if (aggregation_code_cfg[`ACFG_IP6PORT] && frm_is_ip6)
      code = code ^ fold48({16'h0000, frm_l4_ports});
    if (aggregation_code_cfg[`ACFG_IP6FLOW] && frm_is_ip6)
      code = code ^ fold48({28'h0000000, frm_flow_label});
    // random option overrides; spreads a flow, may reorder
    if (aggregation_code_cfg[`ACFG_RND])
      code = lfsr[`AC_MSB:0];
  end

  // -------------------------------------------------------------------------
  // forwarding decision
  // -------------------------------------------------------------------------
  wire [`VLAN_ENTRY_W-1:0] vent = vlan_tbl[frm_vid];
  wire                     src_ok = (frm_src_port <= `PORT_MSB);
  wire [`PORT_MSB:0]       smask = src_ok ? src_mask[frm_src_port]
                                          : {`NUM_PORTS{1'b0}};
  // out-of-range source must not read the filter flag as membership
  wire                     in_vlan = src_ok && vent[frm_src_port];
  wire                     vlan_drop = vent[`SKIP_LEARN_ON_VLAN_FILTER_BIT] && !in_vlan;
  wire                     is_8021x = (frm_dmac == `RSV_ADDR_8021X);
  wire                     redir = src_ok &&
                                   reserved_addr_redirect_en[frm_src_port];
  wire                     p_learn = src_ok && learning_on[frm_src_port];
  wire                     p_cpu = src_ok && learn_copy_to_cpu[frm_src_port];
  wire                     p_drop = src_ok &&
                                    learn_frame_discard[frm_src_port];
  wire                     p_auto = src_ok && automatic_learning[frm_src_port];
  wire                     mac_mode = p_learn && p_cpu && p_drop;

  reg [`DEC_W-1:0]   act;
  reg [`QUEUE_W-1:0] que;
  reg [`PORT_MSB:0]  ports;
  reg                lrn;

  always @* begin
    act   = `DEC_FORWARD;
    que   = {`QUEUE_W{1'b0}};
    // code selects mask, anded with destination
    // masks leave set the members they are written with; reset sets all
    // as many members survive per code as its mask leaves set
    ports = frm_dest & aggr_mask[code] & smask & vent[`PORT_MSB:0];
    lrn   = p_learn && frm_smac_known == 1'b0;
    if (vlan_drop && skip_learn_on_vlan_filter)
      lrn = 1'b0;
    if (is_8021x && redir) begin
      // queue comes from the reserved address queue select
      act   = `DEC_TO_CPU;
      que   = reserved_addr_queue_sel;
      ports = {`NUM_PORTS{1'b0}};
      lrn   = 1'b0;
    end else if (mac_mode && !frm_smac_known) begin
      // unknown sources never reach other ports
      ports = {`NUM_PORTS{1'b0}};
      lrn   = 1'b0;
      if (p_auto) begin
        // secure learning hands the frame to the cpu
        act = `DEC_TO_CPU;
      end else begin
        // cpu must add the entry to unblock this source
        act = `DEC_DISCARD;
      end
    end else if (vlan_drop || ports == {`NUM_PORTS{1'b0}}) begin
      act   = `DEC_DISCARD;
      ports = {`NUM_PORTS{1'b0}};
    end
  end

  // -------------------------------------------------------------------------
  // output buffer: a stalled consumer back-pressures the descriptor source
  // -------------------------------------------------------------------------
  wire [DEC_BITS-1:0] dec_word;

  skid_buffer #(
    .WIDTH (DEC_BITS)
  ) u_out_buf (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .in_valid  (frm_valid),
    .in_ready  (frm_ready),
    .in_data   ({act, que, ports, code, lrn}),
    .out_valid (dec_valid),
    .out_ready (dec_ready),
    .out_data  (dec_word)
  );

  // unpack; all fields come from the buffer's registers
  assign dec_action = dec_word[DEC_BITS-1 -: `DEC_W];
  assign dec_queue  = dec_word[DEC_BITS-`DEC_W-1 -: `QUEUE_W];
  assign dec_ports  = dec_word[`AC_W+`NUM_PORTS : `AC_W+1];
  assign dec_code   = dec_word[`AC_W:1];
  assign dec_learn  = dec_word[0];

endmodule // fwd_filter
`default_nettype wire

// ### design/fwd_filter_defs.vh
// Purpose: constants for the access control and aggregation forwarding filter
// Assumes: 27 ports, 16 aggregation masks, 4-bit aggregation code
// Notes:   offsets, codes and widths of the filter are named here, save the frame field and lfsr widths
`ifndef FWD_FILTER_DEFS_VH
`define FWD_FILTER_DEFS_VH

`define NUM_PORTS        27
`define PORT_W           5
`define PORT_MSB         26
`define AGGR_MASKS       16
`define AC_W             4
`define AC_MSB           3
`define QUEUE_W          3
`define VLAN_W           12
`define VLAN_DEPTH       4096
`define VLAN_ENTRY_W     28
`define SKIP_LEARN_ON_VLAN_FILTER_BIT     27
`define VLAN_CMD_W       2
`define VLAN_CMD_WRITE   2'h2
// reserved address used by port access control
`define RSV_ADDR_8021X   48'h0180c2000003
// contribution enables in aggregation_code_cfg
`define ACFG_W           7
`define ACFG_SMAC        0
`define ACFG_DMAC        1
`define ACFG_SIPDIP      2
`define ACFG_IP4PORT     3
`define ACFG_IP6PORT     4
`define ACFG_IP6FLOW     5
`define ACFG_RND         6
// decision codes on the output stream
`define DEC_W            2
`define DEC_FORWARD      2'h0
`define DEC_TO_CPU       2'h1
`define DEC_DISCARD      2'h2
`define LFSR_SEED        16'hace1

`endif

// ### design/skid_buffer.v
// Purpose: two-entry buffer with valid and ready on both sides
// Assumes: single clock, asynchronous active-low reset
// Notes:   ready toward the source is registered, so a stall loses no word
`default_nettype none
`include "fwd_filter_defs.vh"

module skid_buffer #(
  parameter WIDTH = 8
) (
  // clock and reset
  input  wire             sys_clk,
  input  wire             rst_n,
  // filling side
  input  wire             in_valid,
  output reg              in_ready,
  input  wire [WIDTH-1:0] in_data,
  // draining side
  output reg              out_valid,
  input  wire             out_ready,
  output reg  [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] spare;
  reg             spare_valid;

  // -------------------------------------------------------------------------
  // two slots: output register plus a spare for the word in flight
  // -------------------------------------------------------------------------
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid   <= 1'b0;
      out_data    <= {WIDTH{1'b0}};
      spare       <= {WIDTH{1'b0}};
      spare_valid <= 1'b0;
      in_ready    <= 1'b1;
    end else begin
      if (!out_valid || out_ready) begin
        // output slot frees: refill from spare first to keep order
        if (spare_valid) begin
          out_valid   <= 1'b1;
          out_data    <= spare;
          spare_valid <= 1'b0;
          in_ready    <= 1'b1;
        end else begin
          out_valid <= in_valid && in_ready;
          out_data  <= in_data;
        end
      end else if (in_valid && in_ready) begin
        // receiver stalled: park the word, stop the source
        spare       <= in_data;
        spare_valid <= 1'b1;
        in_ready    <= 1'b0;
      end
    end
  end

endmodule // skid_buffer
`default_nettype wire

// ### test/fwd_filter_chk.sv
// Purpose: port-level checks of the forwarding filter
// Assumes: an idle buffer gives the decision one cycle after the take
// Notes:   mask tables are internal, so the bench judges those
`default_nettype none
`include "fwd_filter_defs.vh"
module fwd_filter_chk (
  // clock, reset and controls
  input wire logic                sys_clk,
  input wire logic                rst_n,
  input wire logic [`PORT_MSB:0]  reserved_addr_redirect_en,
  input wire logic [`QUEUE_W-1:0] reserved_addr_queue_sel,
  input wire logic [`PORT_MSB:0]  learning_on,
  input wire logic [`PORT_MSB:0]  learn_copy_to_cpu,
  input wire logic [`PORT_MSB:0]  learn_frame_discard,
  input wire logic [`PORT_MSB:0]  automatic_learning,
  input wire logic [`ACFG_W-1:0]  aggregation_code_cfg,
  // descriptor and decision streams
  input wire logic                frm_valid,
  input wire logic                frm_ready,
  input wire logic [`PORT_W-1:0]  frm_src_port,
  input wire logic [47:0]         frm_dmac,
  input wire logic [47:0]         frm_smac,
  input wire logic                frm_smac_known,
  input wire logic [`PORT_MSB:0]  frm_dest,
  input wire logic                dec_valid,
  input wire logic                dec_ready,
  input wire logic [`DEC_W-1:0]   dec_action,
  input wire logic [`QUEUE_W-1:0] dec_queue,
  input wire logic [`PORT_MSB:0]  dec_ports,
  input wire logic [`AC_MSB:0]    dec_code
);
  // only a take into a free or draining output slot has a fixed answer cycle
  wire logic take = frm_valid && frm_ready && (!dec_valid || dec_ready);
  wire logic rsv = frm_dmac == `RSV_ADDR_8021X &&
    reserved_addr_redirect_en[frm_src_port];
  wire logic unk = learning_on[frm_src_port] && !frm_smac_known &&
    learn_copy_to_cpu[frm_src_port] && learn_frame_discard[frm_src_port];
  wire logic aut = automatic_learning[frm_src_port];
  function automatic logic [3:0] nib(input logic [47:0] v);
    nib = 4'h0;
    for (int i = 0; i < 12; i++) nib ^= v[4*i +: 4];
  endfunction
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_rsv_to_cpu: assert property (take && rsv |=> dec_valid &&
    dec_action == `DEC_TO_CPU) else $error("reserved frame not to cpu");
  a_rsv_queue_sel: assert property (take && rsv |=>
    dec_queue == $past(reserved_addr_queue_sel) && dec_ports == 27'h0)
    else $error("redirected frame in wrong queue");
  a_secure_to_cpu: assert property (take && unk && !rsv && aut |=>
    dec_action == `DEC_TO_CPU) else $error("unknown source not to cpu");
  a_nolearn_drop: assert property (take && unk && !rsv && !aut |=>
    dec_action == `DEC_DISCARD) else $error("unknown source not dropped");
  a_known_only: assert property (take && unk && !rsv |=>
    dec_ports == 27'h0) else $error("unknown source forwarded");
  a_code_smac: assert property (take && aggregation_code_cfg == 7'h01
    |=> dec_code == nib($past(frm_smac))) else $error("bad smac code");
  a_ports_in_dest: assert property (take |=>
    (dec_ports & ~$past(frm_dest)) == 27'h0) else $error("port not in dest");
  a_dec_hold: assert property (dec_valid && !dec_ready |=> dec_valid &&
    $stable(dec_ports) && $stable(dec_action)) else $error("decision lost");
endmodule // fwd_filter_chk
bind fwd_filter fwd_filter_chk chk (.sys_clk, .rst_n,
  .reserved_addr_redirect_en, .reserved_addr_queue_sel, .learning_on,
  .learn_copy_to_cpu, .learn_frame_discard, .automatic_learning,
  .aggregation_code_cfg, .frm_valid, .frm_ready, .frm_src_port, .frm_dmac,
  .frm_smac, .frm_smac_known, .frm_dest, .dec_valid, .dec_ready,
  .dec_action, .dec_queue, .dec_ports, .dec_code);
`default_nettype wire

// ### test/dec_sink.sv
// Purpose: model of the ports and cpu taking decisions
// Assumes: ready changes just after the rising edge
// Notes:   slow mode stalls three cycles in four to fill the buffer
`default_nettype none
module dec_sink (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // stream
  input wire logic slow,
  input wire logic dec_valid,
  output var logic dec_ready
);
  logic [7:0] r;
  // pseudo-random stall pattern
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= 8'h5a;
      dec_ready <= 1'b0;
    end else begin
      r <= {r[6:0], r[7] ^ r[5] ^ r[4] ^ r[3]};
      dec_ready <= !slow || (r[1:0] == 2'h0);
    end
  end
endmodule // dec_sink
`default_nettype wire

// ### test/tb_top.sv
// Purpose: self-checking bench of the forwarding filter
// Assumes: decision sink model on the output side
// Notes:   random frames from a fixed lfsr seed, corner frames mixed in
`default_nettype none
`include "fwd_filter_defs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [1:0] a; logic [2:0] q; logic [26:0] p;
    logic [3:0] c; logic l; logic [2:0] m;} exp_t;
  logic sys_clk = 0, rst_n = 0, skip_learn_on_vlan_filter = 1, slow = 0;
  logic mask_wr = 0, mask_is_src = 0, vlan_ingress_filter_on = 0;
  logic frm_valid = 0, frm_smac_known = 0, frm_is_ip4 = 0, frm_is_ip6 = 0;
  logic [26:0] reserved_addr_redirect_en = 27'h7ffffdf, mask_data = 0;
  logic [26:0] learning_on = 27'h7ffffff, learn_copy_to_cpu = 27'hc;
  logic [26:0] learn_frame_discard = 27'hc, frm_dest = 0;
  logic [26:0] automatic_learning = 27'h7fffff7, vlan_member_ports = 0;
  logic [2:0] reserved_addr_queue_sel = 3'h5;
  logic [6:0] aggregation_code_cfg = 7'h01;
  logic [4:0] mask_idx = 0, frm_src_port = 0;
  logic [1:0] vlan_table_op = 0;
  logic [11:0] vlan_table_index = 0, frm_vid = 0;
  logic [47:0] frm_dmac = 0, frm_smac = 0;
  logic [31:0] frm_sip = 0, frm_dip = 0, frm_l4_ports = 0;
  logic [19:0] frm_flow_label = 0;
  wire logic frm_ready, dec_valid, dec_ready, dec_learn;
  wire logic [1:0] dec_action;
  wire logic [2:0] dec_queue;
  wire logic [26:0] dec_ports;
  wire logic [3:0] dec_code;
  logic [26:0] agg [16], srcm [27], vm [4096];
  logic vf [4096];
  logic [15:0] seed = 16'd573;
  int miscompares = 0, check_count = 0, refusals = 0;
  exp_t eq [$];
  exp_t ex;
  fwd_filter uut (.sys_clk, .rst_n, .reserved_addr_redirect_en,
    .reserved_addr_queue_sel, .learning_on, .learn_copy_to_cpu,
    .learn_frame_discard, .automatic_learning, .skip_learn_on_vlan_filter,
    .aggregation_code_cfg, .mask_wr, .mask_is_src, .mask_idx, .mask_data,
    .vlan_table_op, .vlan_table_index, .vlan_ingress_filter_on,
    .vlan_member_ports, .frm_valid, .frm_ready, .frm_src_port, .frm_vid,
    .frm_dmac, .frm_smac, .frm_smac_known, .frm_dest, .frm_is_ip4,
    .frm_is_ip6, .frm_sip, .frm_dip, .frm_l4_ports, .frm_flow_label,
    .dec_valid, .dec_ready, .dec_action, .dec_queue, .dec_ports, .dec_code,
    .dec_learn);
  dec_sink sink (.sys_clk, .rst_n, .slow, .dec_valid, .dec_ready);
  always #5 sys_clk = ~sys_clk;
  function logic [15:0] rw();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    rw = seed;
  endfunction
  task automatic cmp(input string n, input logic [31:0] x, g);
    check_count++;
    if (g !== x) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // mask write; the caller lowers the strobe after the last one
  task automatic wmask(input logic s, input int i, input logic [26:0] d);
    {mask_wr, mask_is_src, mask_idx, mask_data} = {1'b1, s, 5'(i), d};
    if (s) srcm[i] = d;
    else agg[i] = d;
    @(negedge sys_clk);
  endtask
  task automatic wvlan(input logic [1:0] op, input int v, input logic f,
      input logic [26:0] d);
    {vlan_table_op, vlan_table_index} = {op, 12'(v)};
    {vlan_ingress_filter_on, vlan_member_ports} = {f, d};
    if (op == `VLAN_CMD_WRITE) {vf[v], vm[v]} = {f, d};
    @(negedge sys_clk);
  endtask
  // push the expectation, then offer the descriptor until it is taken
  task automatic send(input logic [4:0] s, input logic [11:0] v,
      input logic [47:0] d, sm, input logic k, input logic [26:0] ds);
    exp_t e;
    logic vd;
    int n;
    e = '{`DEC_FORWARD, reserved_addr_queue_sel, 0, 0, 0, 3'h1};
    for (n = 0; n < 12; n++) e.c ^= sm[4*n +: 4];
    e.m[1] = aggregation_code_cfg[`ACFG_RND];
    vd = vf[v] && !vm[v][s];
    if (d == `RSV_ADDR_8021X && reserved_addr_redirect_en[s]) begin
      {e.a, e.m[2]} = {`DEC_TO_CPU, 1'b1};
    end else if (learn_copy_to_cpu[s] && learn_frame_discard[s] && !k) begin
      e.a = automatic_learning[s] ? `DEC_TO_CPU : `DEC_DISCARD;
      e.m[0] = 1'b0;
    end else begin
      e.p = ds & agg[e.c] & srcm[s] & vm[v];
      e.l = learning_on[s] && !k && !(vd && skip_learn_on_vlan_filter);
      if (vd || e.p == 0) {e.a, e.p} = {`DEC_DISCARD, 27'h0};
    end
    eq.push_back(e);
    {frm_src_port, frm_vid, frm_dmac, frm_smac} = {s, v, d, sm};
    {frm_smac_known, frm_dest, frm_valid} = {k, ds, 1'b1};
    {frm_sip, frm_dip, frm_l4_ports} = {rw(), rw(), rw(), rw(), rw(), rw()};
    {frm_is_ip4, frm_is_ip6, frm_flow_label} = {rw(), rw(), rw()};
    for (n = 0; n < 100 && !frm_ready; n++) @(negedge sys_clk);
    if (n == 100) begin
      miscompares++;
      finish_test();
    end
    @(negedge sys_clk);
  endtask
  task automatic run(input string nm, input int cnt);
    logic [15:0] r;
    logic [4:0] s;
    for (int j = 0; j < cnt; j++) begin
      r = rw();
      s = 5'(r % 27);
      send(s, r[5] ? 12'd20 : 12'd21, r[9:6] == 0 ? `RSV_ADDR_8021X :
        {rw(), rw(), rw()}, {rw(), rw(), 16'h0}, r[10],
        27'({rw(), rw()}) & ~(27'h1 << s));
    end
    $display("test %s done", nm);
  endtask
  // decisions are compared as the sink takes them
  always @(negedge sys_clk) begin
    if (rst_n && frm_valid && !frm_ready) refusals++;
    if (rst_n && dec_valid && dec_ready && eq.size() == 0)
      cmp("extra decision", 0, 1);
    else if (rst_n && dec_valid && dec_ready) begin
      ex = eq.pop_front();
      if (!ex.m[1]) cmp("action", ex.a, dec_action);
      if (!ex.m[1]) cmp("ports", ex.p, dec_ports);
      if (!ex.m[1]) cmp("code", ex.c, dec_code);
      if (ex.m[2]) cmp("queue", ex.q, dec_queue);
      if (ex.m[0]) cmp("learn", ex.l, dec_learn);
      cmp("one member", 1, $countones(dec_ports & 27'h33) <= 1);
    end
  end
  initial begin
    for (int i = 0; i < 27; i++) {agg[i % 16], srcm[i]} = '1;
    repeat (20) @(negedge sys_clk);
    rst_n = 1'b1;
    // lag of ports 0,1,4,5 picks one member per code; port 9 shut out
    // every port sits in this one group or none
    // the model treats all members as equal speed
    for (int i = 0; i < 16; i++) wmask(0, i, 27'h7fffdcc |
      (27'h1 << ((i & 2) ? (i & 1) + 4 : (i & 1))));
    wmask(1, 6, 27'h0);
    mask_wr = 1'b0;
    wvlan(2, 20, 0, 27'h7ffffff);
    wvlan(2, 21, 1, 27'h800);
    for (int o = 0; o < 4; o++) if (o != 2) wvlan(o, 21, 0, '1);
    vlan_table_op = 2'h0;
    send(6, 20, `RSV_ADDR_8021X, 48'h1, 0, 27'h7ffffbf);
    send(5, 20, `RSV_ADDR_8021X, 48'h2, 1, 27'h7ffffdf);
    send(2, 20, 48'h3, 48'h4, 0, 27'h7fffffb);
    send(3, 20, 48'h3, 48'h4, 0, 27'h7fffff7);
    send(3, 20, 48'h3, 48'h4, 1, 27'h7fffff7);
    send(10, 21, 48'h3, 48'h5, 0, 27'h7fffbff);
    skip_learn_on_vlan_filter = 1'b0;
    send(10, 21, 48'h3, 48'h6, 0, 27'h7fffbff);
    run("random fast", 150);
    {slow, reserved_addr_redirect_en, skip_learn_on_vlan_filter} = '1;
    run("stalled sink", 150);
    cmp("refusals seen", 1, refusals > 0);
    aggregation_code_cfg = 7'h41;
    run("random code", 40);
    frm_valid = 1'b0;
    for (int n = 0; n < 500 && eq.size() > 0; n++) @(negedge sys_clk);
    cmp("left over", 0, eq.size());
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
